// ### core/mho_map.vh
// register map, field positions, reset values and timing of the hold/output stage
`ifndef MHO_MAP_VH
`define MHO_MAP_VH

// byte offsets
`define MHO_CTRL        8'h00
`define MHO_SP1         8'h04
`define MHO_SP2         8'h08
`define MHO_HYST        8'h0C
`define MHO_TOL         8'h10
`define MHO_DELAY       8'h14
`define MHO_ANA_LO      8'h18
`define MHO_ANA_HI      8'h1C
`define MHO_STATUS      8'h20
`define MHO_HOLD        8'h24
`define MHO_TEACH       8'h28
`define MHO_ANALOG      8'h2C

// control word fields
`define MHO_F_INFUNC    1:0
`define MHO_F_INPOL     2
`define MHO_F_DEBOUNCE  3
`define MHO_F_HOLDMODE  6:4
`define MHO_F_OUTFUNC   9:8
`define MHO_F_DIGMODE   14:12
`define MHO_F_ACTLOW    15
`define MHO_F_DLYMODE   18:16
`define MHO_F_ADVANCED  19

// reset values, distances in 0.1 mm
`define MHO_RST_CTRL    32'h0000_0008
`define MHO_RST_SP1     32'h0000_0FA0
`define MHO_RST_SP2     32'hFFFF_F060
`define MHO_RST_HYST    32'h0000_000A
`define MHO_RST_TOL     32'h0000_0028
`define MHO_RST_DELAY   32'h0000_0064
`define MHO_RST_ANA_LO  32'hFFFF_F060
`define MHO_RST_ANA_HI  32'h0000_0FA0

// value ranges
`define MHO_DIST_MIN    32'hFFFF_D8F0
`define MHO_DIST_MAX    32'h0000_2710
`define MHO_HYST_MAX    32'h0000_03E8
`define MHO_DELAY_MAX   32'h0000_270F

// timing
`define MHO_CLK_HZ      10000000
`define MHO_MS_CYCLES   (`MHO_CLK_HZ / 1000)
`define MHO_DEBOUNCE_MS 30
`define MHO_TEACH_TOL_MS 20
`define MHO_TEACH_STEP_MS 100
`define MHO_LASER_OFF_MS 5000

`endif

// ### core/mho_top.v
// measured-value hold, second output and control input stage
//
// Contract
// - sample hold captures value at rising edge
// - peak hold outputs interval maximum
// - bottom hold outputs interval minimum
// - peak-to-peak outputs maximum minus minimum
// - average hold outputs interval arithmetic mean
// - laser off while input asserted
// - input cannot disable itself
// - input polarity high or low active
// - polarity decides laser off or on
// - second output current, voltage, digital, off
// - two analog endpoint distances, limited range
// - seven digital switching modes
// - advanced modes need advanced user level
// - single point settable, default +400 mm
// - window uses two independent points
// - selectable active level, default high
// - hysteresis 0 to 100 mm
// - delay modes and delay time
// - background mode with tolerance
// - analog output linear between endpoints
// - teach pulse tolerance plus minus 20 ms
// - debounce needs 30 ms stable level
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "mho_map.vh"

module mho_top #(
	parameter MS_CYCLES = `MHO_MS_CYCLES,
	parameter DW        = 20
) (
	input  wire                 aclk,
	input  wire                 aresetn,
	input  wire [7:0]           s_axi_awaddr,
	input  wire                 s_axi_awvalid,
	output wire                 s_axi_awready,
	input  wire [31:0]          s_axi_wdata,
	input  wire [3:0]           s_axi_wstrb,
	input  wire                 s_axi_wvalid,
	output wire                 s_axi_wready,
	output reg  [1:0]           s_axi_bresp,
	output reg                  s_axi_bvalid,
	input  wire                 s_axi_bready,
	input  wire [7:0]           s_axi_araddr,
	input  wire                 s_axi_arvalid,
	output wire                 s_axi_arready,
	output reg  [31:0]          s_axi_rdata,
	output reg  [1:0]           s_axi_rresp,
	output reg                  s_axi_rvalid,
	input  wire                 s_axi_rready,
	input  wire signed [DW-1:0] meas_value,
	input  wire                 meas_valid,
	input  wire                 meas_ok,
	input  wire                 level_low,
	input  wire                 edge_jump,
	input  wire                 first_switch_output,
	input  wire                 control_input,
	output reg                  second_switch_output,
	output reg  [15:0]          analog_output,
	output reg                  analog_enable,
	output reg                  analog_is_voltage,
	output reg                  laser_on,
	output reg  signed [DW:0]   hold_value,
	output reg                  hold_strobe,
	output reg  [4:0]           teach_code,
	output reg                  teach_strobe
);

	localparam [1:0] IN_TEACH = 2'd0, IN_HOLD = 2'd1, IN_LASER = 2'd2, IN_OFF = 2'd3;
	localparam [2:0] H_SAMPLE = 3'd0, H_PEAK = 3'd1, H_BOTTOM = 3'd2, H_P2P = 3'd3;
	localparam [2:0] H_AVG = 3'd4;
	localparam [1:0] O_CURR = 2'd0, O_VOLT = 2'd1, O_DIG = 2'd2;
	localparam [2:0] D_DTO = 3'd0, D_WIN = 3'd1, D_BG = 3'd2, D_INV = 3'd3;
	localparam [2:0] D_ALARM = 3'd4, D_LEVEL = 3'd5, D_EDGE = 3'd6;
	localparam [2:0] Y_OFF = 3'd0, Y_ON = 3'd1, Y_OFFD = 3'd2, Y_BOTH = 3'd3, Y_SHOT = 3'd4;
	localparam [4:0] T_LASER_OFF = 5'd2, T_LASER_ON = 5'd3;

	// byte-lane merge of a write
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
			end
		end
	endfunction

	// limit a signed value to a range
	function [31:0] clampv;
		input [31:0] v;
		input [31:0] lo;
		input [31:0] hi;
		begin
			if ($signed(v) < $signed(lo)) begin
				clampv = lo;
			end else if ($signed(v) > $signed(hi)) begin
				clampv = hi;
			end else begin
				clampv = v;
			end
		end
	endfunction

	// sign extension to the compare width
	function signed [DW+1:0] sx;
		input [31:0] v;
		begin
			sx = $signed(v[DW+1:0]);
		end
	endfunction

	reg [31:0] ctrl;
	reg [31:0] sp1;
	reg [31:0] sp2;
	reg [31:0] hyst;
	reg [31:0] tol;
	reg [31:0] delay_ms;
	reg [31:0] ana_lo;
	reg [31:0] ana_hi;

	wire [1:0] in_func  = ctrl[`MHO_F_INFUNC];
	wire [2:0] hmode    = ctrl[`MHO_F_HOLDMODE];
	wire [1:0] out_func = ctrl[`MHO_F_OUTFUNC];
	wire [2:0] dmode    = ctrl[`MHO_F_DIGMODE];
	wire [2:0] ymode    = ctrl[`MHO_F_DLYMODE];

	// bus write side
	reg        aw_hold;
	reg        w_hold;
	reg [7:0]  aw_addr;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	wire       do_write = aw_hold && w_hold && !s_axi_bvalid;
	wire [31:0] wv_ctrl = merge(ctrl, w_data, w_strb);

	assign s_axi_awready = !aw_hold;
	assign s_axi_wready  = !w_hold;
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold      <= 1'b0;
			w_hold       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
			ctrl         <= `MHO_RST_CTRL;
			sp1          <= `MHO_RST_SP1;
			sp2          <= `MHO_RST_SP2;
			hyst         <= `MHO_RST_HYST;
			tol          <= `MHO_RST_TOL;
			delay_ms     <= `MHO_RST_DELAY;
			ana_lo       <= `MHO_RST_ANA_LO;
			ana_hi       <= `MHO_RST_ANA_HI;
		end else begin
			if (s_axi_awvalid && !aw_hold) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_hold) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (do_write) begin
				aw_hold      <= 1'b0;
				w_hold       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'b00;
				case (aw_addr)
					`MHO_CTRL: begin
						if (wv_ctrl[14] && !wv_ctrl[`MHO_F_ADVANCED]) begin
							ctrl <= {wv_ctrl[31:15], ctrl[14:12], wv_ctrl[11:0]};
						end else begin
							ctrl <= wv_ctrl;
						end
					end
					`MHO_SP1: sp1 <= clampv(merge(sp1, w_data, w_strb),
						`MHO_DIST_MIN, `MHO_DIST_MAX);
					`MHO_SP2: sp2 <= clampv(merge(sp2, w_data, w_strb),
						`MHO_DIST_MIN, `MHO_DIST_MAX);
					`MHO_HYST: hyst <= clampv(merge(hyst, w_data, w_strb),
						32'h0000_0000, `MHO_HYST_MAX);
					`MHO_TOL: tol <= clampv(merge(tol, w_data, w_strb),
						`MHO_DIST_MIN, `MHO_DIST_MAX);
					`MHO_DELAY: delay_ms <= clampv(merge(delay_ms, w_data, w_strb),
						32'h0000_0000, `MHO_DELAY_MAX);
					`MHO_ANA_LO: ana_lo <= clampv(merge(ana_lo, w_data, w_strb),
						`MHO_DIST_MIN, `MHO_DIST_MAX);
					`MHO_ANA_HI: ana_hi <= clampv(merge(ana_hi, w_data, w_strb),
						`MHO_DIST_MIN, `MHO_DIST_MAX);
					`MHO_STATUS, `MHO_HOLD, `MHO_TEACH, `MHO_ANALOG: s_axi_bresp <= 2'b00;
					default: s_axi_bresp <= 2'b10;
				endcase
			end
		end
	end

	// millisecond enable
	reg  [15:0] ms_div;
	wire        ms_tick = (ms_div == MS_CYCLES[15:0] - 16'd1);

	always @(posedge aclk) begin
		if (!aresetn) begin
			ms_div <= 16'h0000;
		end else begin
			ms_div <= ms_tick ? 16'h0000 : ms_div + 16'd1;
		end
	end

	reg       in_s1;
	reg       in_s2;
	reg       db_level;
	reg [5:0] db_cnt;
	reg       asrt_q;
	wire      line = ctrl[`MHO_F_DEBOUNCE] ? db_level : in_s2;
	wire      asserted = (in_func != IN_OFF) && (line ^ ctrl[`MHO_F_INPOL]);
	wire      rise = asserted && !asrt_q;
	wire      fall = !asserted && asrt_q;

	always @(posedge aclk) begin
		if (!aresetn) begin
			in_s1    <= 1'b0;
			in_s2    <= 1'b0;
			db_level <= 1'b0;
			db_cnt   <= 6'd0;
			asrt_q   <= 1'b0;
		end else begin
			in_s1  <= control_input;
			in_s2  <= in_s1;
			asrt_q <= asserted;
			if (in_s2 == db_level) begin
				db_cnt <= 6'd0;
			end else if (ms_tick) begin
				if (db_cnt >= `MHO_DEBOUNCE_MS - 1) begin
					db_level <= in_s2;
					db_cnt   <= 6'd0;
				end else begin
					db_cnt <= db_cnt + 6'd1;
				end
			end
		end
	end

	// teach pulse length and laser control
	reg  [12:0] pulse_ms;
	reg         teach_laser_off;
	wire [31:0] pulse_adj = {19'h0_0000, pulse_ms} + `MHO_TEACH_TOL_MS;
	wire [31:0] pulse_rem = pulse_adj % `MHO_TEACH_STEP_MS;
	wire [31:0] pulse_idx = pulse_adj / `MHO_TEACH_STEP_MS;
	wire        long_press = (in_func == IN_TEACH) && asserted &&
		(pulse_ms > `MHO_LASER_OFF_MS);

	always @(posedge aclk) begin
		if (!aresetn) begin
			pulse_ms        <= 13'd0;
			teach_code      <= 5'd0;
			teach_strobe    <= 1'b0;
			teach_laser_off <= 1'b0;
			laser_on        <= 1'b1;
		end else begin
			teach_strobe <= 1'b0;
			if (rise) begin
				pulse_ms <= 13'd0;
			end else if (asserted && ms_tick && pulse_ms != 13'h1FFF) begin
				pulse_ms <= pulse_ms + 13'd1;
			end
			if (fall && in_func == IN_TEACH && pulse_rem <= 2 * `MHO_TEACH_TOL_MS &&
				pulse_idx >= 13'd2 && pulse_idx <= 13'd29) begin
				teach_code   <= pulse_idx[4:0];
				teach_strobe <= 1'b1;
				if (pulse_idx[4:0] == T_LASER_OFF) begin
					teach_laser_off <= 1'b1;
				end else if (pulse_idx[4:0] == T_LASER_ON) begin
					teach_laser_off <= 1'b0;
				end
			end
			laser_on <= !(teach_laser_off || long_press ||
				(in_func == IN_LASER && asserted));
		end
	end

	reg signed [DW-1:0]  hmax;
	reg signed [DW-1:0]  hmin;
	reg signed [DW+19:0] hacc;
	reg [19:0]           hcnt;
	wire signed [DW+19:0] hmean = hacc / $signed({1'b0, hcnt});
	wire                  hold_on = (in_func == IN_HOLD);

	always @(posedge aclk) begin
		if (!aresetn) begin
			hmax        <= {DW{1'b0}};
			hmin        <= {DW{1'b0}};
			hacc        <= {(DW+20){1'b0}};
			hcnt        <= 20'd0;
			hold_value  <= {(DW+1){1'b0}};
			hold_strobe <= 1'b0;
		end else begin
			hold_strobe <= 1'b0;
			if (hold_on && fall) begin
				hmax <= meas_value;
				hmin <= meas_value;
				hacc <= {{20{meas_value[DW-1]}}, meas_value};
				hcnt <= 20'd1;
			end else if (hold_on && !asserted && meas_valid && hcnt != 20'hF_FFFF) begin
				if (meas_value > hmax) hmax <= meas_value;
				if (meas_value < hmin) hmin <= meas_value;
				hacc <= hacc + {{20{meas_value[DW-1]}}, meas_value};
				hcnt <= hcnt + 20'd1;
			end
			if (hold_on && rise) begin
				hold_strobe <= 1'b1;
				case (hmode)
					H_SAMPLE: hold_value <= {meas_value[DW-1], meas_value};
					H_PEAK:   hold_value <= (hcnt == 20'd0) ?
						{meas_value[DW-1], meas_value} : {hmax[DW-1], hmax};
					H_BOTTOM: hold_value <= (hcnt == 20'd0) ?
						{meas_value[DW-1], meas_value} : {hmin[DW-1], hmin};
					H_P2P:    hold_value <= (hcnt == 20'd0) ? {(DW+1){1'b0}} :
						{hmax[DW-1], hmax} - {hmin[DW-1], hmin};
					H_AVG:    hold_value <= (hcnt == 20'd0) ?
						{meas_value[DW-1], meas_value} : hmean[DW:0];
					default:  hold_value <= {meas_value[DW-1], meas_value};
				endcase
			end
		end
	end

	// value feeding the second output
	wire signed [DW+1:0] src = hold_on ? {hold_value[DW], hold_value} :
		{{2{meas_value[DW-1]}}, meas_value};

	reg                  cond_q;
	reg                  cond_n;
	wire signed [DW+1:0] p1 = sx(sp1);
	wire signed [DW+1:0] p2 = sx(sp2);
	wire signed [DW+1:0] hy = sx(hyst);
	wire signed [DW+1:0] lo = (p1 < p2) ? p1 : p2;
	wire signed [DW+1:0] hi = (p1 < p2) ? p2 : p1;
	wire signed [DW+1:0] dev = (src > p1) ? src - p1 : p1 - src;

	always @* begin
		case (dmode)
			D_DTO:   cond_n = cond_q ? (src <= p1 + hy) : (src <= p1);
			D_WIN:   cond_n = cond_q ? (src >= lo - hy && src <= hi + hy) :
				(src >= lo && src <= hi);
			D_BG:    cond_n = cond_q ? (dev + hy > sx(tol)) : (dev > sx(tol));
			D_INV:   cond_n = !first_switch_output;
			D_ALARM: cond_n = ctrl[`MHO_F_ADVANCED] && !meas_ok;
			D_LEVEL: cond_n = ctrl[`MHO_F_ADVANCED] && level_low;
			D_EDGE:  cond_n = ctrl[`MHO_F_ADVANCED] && edge_jump;
			default: cond_n = 1'b0;
		endcase
	end

	reg        cond_d;
	reg        dly_q;
	reg [13:0] dly_cnt;
	wire       dly_dir = cond_q ? (ymode == Y_ON || ymode == Y_BOTH) :
		(ymode == Y_OFFD || ymode == Y_BOTH);

	always @(posedge aclk) begin
		if (!aresetn) begin
			cond_q  <= 1'b0;
			cond_d  <= 1'b0;
			dly_q   <= 1'b0;
			dly_cnt <= 14'd0;
		end else begin
			cond_q <= cond_n;
			cond_d <= cond_q;
			if (ymode == Y_SHOT) begin
				if (cond_q && !cond_d) begin
					dly_q   <= (delay_ms != 32'h0000_0000);
					dly_cnt <= 14'd0;
				end else if (dly_q && ms_tick) begin
					dly_cnt <= dly_cnt + 14'd1;
					if ({18'h0_0000, dly_cnt} + 32'h0000_0001 >= delay_ms) begin
						dly_q <= 1'b0;
					end
				end
			end else if (cond_q == dly_q) begin
				dly_cnt <= 14'd0;
			end else if (!dly_dir || {18'h0_0000, dly_cnt} >= delay_ms) begin
				dly_q   <= cond_q;
				dly_cnt <= 14'd0;
			end else if (ms_tick) begin
				dly_cnt <= dly_cnt + 14'd1;
			end
		end
	end

	wire signed [DW+1:0]  a_lo = sx(ana_lo);
	wire signed [DW+1:0]  a_span = sx(ana_hi) - a_lo;
	wire signed [DW+19:0] a_num = (src - a_lo) * $signed(18'sh0_FFFF);
	wire signed [DW+19:0] a_val = (a_span == 0) ? {(DW+20){1'b0}} : a_num / a_span;

	always @(posedge aclk) begin
		if (!aresetn) begin
			second_switch_output <= 1'b0;
			analog_output        <= 16'h0000;
			analog_enable        <= 1'b0;
			analog_is_voltage    <= 1'b0;
		end else begin
			analog_enable        <= (out_func == O_CURR) || (out_func == O_VOLT);
			analog_is_voltage    <= (out_func == O_VOLT);
			second_switch_output <= (out_func == O_DIG) && (dly_q ^ ctrl[`MHO_F_ACTLOW]);
			if (out_func != O_CURR && out_func != O_VOLT) begin
				analog_output <= 16'h0000;
			end else if (a_val < 0) begin
				analog_output <= 16'h0000;
			end else if (a_val > 65535) begin
				analog_output <= 16'hFFFF;
			end else begin
				analog_output <= a_val[15:0];
			end
		end
	end

	// bus read side
	reg [31:0] rd_mux;
	reg        rd_err;

	always @* begin
		rd_err = 1'b0;
		case (s_axi_araddr)
			`MHO_CTRL:   rd_mux = ctrl;
			`MHO_SP1:    rd_mux = sp1;
			`MHO_SP2:    rd_mux = sp2;
			`MHO_HYST:   rd_mux = hyst;
			`MHO_TOL:    rd_mux = tol;
			`MHO_DELAY:  rd_mux = delay_ms;
			`MHO_ANA_LO: rd_mux = ana_lo;
			`MHO_ANA_HI: rd_mux = ana_hi;
			`MHO_STATUS: rd_mux = {26'h000_0000, dly_q, cond_q, line, asserted,
				second_switch_output, laser_on};
			`MHO_HOLD:   rd_mux = {{(31-DW){hold_value[DW]}}, hold_value};
			`MHO_TEACH:  rd_mux = {11'h000, teach_code, 3'b000, pulse_ms};
			`MHO_ANALOG: rd_mux = {16'h0000, analog_output};
			default: begin
				rd_mux = 32'h0000_0000;
				rd_err = 1'b1;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'b00;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_err ? 2'b10 : 2'b00;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // mho_top

// ### verification/measurement_hold_output_control_tb.sv
// self-checking bench of the hold and second output stage
`timescale 1ns/100ps
`include "mho_map.vh"
module measurement_hold_output_control_tb;
	localparam int MS = 10;
	localparam logic [15:0] YE = 16'h86E4;
	reg               aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	reg        [7:0]  awaddr, araddr;
	reg        [31:0] wdata;
	reg signed [19:0] meas_value;
	reg               meas_valid, meas_ok, level_low, edge_jump, first_q;
	wire              awready, wready, bvalid, arready, rvalid, ctl, second_q;
	wire              ana_en, ana_v, laser_on, hold_strobe, teach_strobe;
	wire       [1:0]  bresp, rresp;
	wire       [31:0] rdata;
	wire       [15:0] ana;
	wire signed [20:0] hold_value;
	wire       [4:0]  teach_code;
	int               mismatches, checks_done, v, ex;
	logic      [31:0] rd;
	logic      [1:0]  rs;
	logic      [31:0] rst [8] = '{`MHO_RST_CTRL, `MHO_RST_SP1, `MHO_RST_SP2, `MHO_RST_HYST,
		`MHO_RST_TOL, `MHO_RST_DELAY, `MHO_RST_ANA_LO, `MHO_RST_ANA_HI};
	logic      [31:0] cd [5] = '{32'h0000_4E20, 32'hFFFF_B1E0, 32'h0000_07D0, 32'h0000_4E20,
		32'h0000_4E20};
	logic      [31:0] ce [5] = '{`MHO_DIST_MAX, `MHO_DIST_MIN, `MHO_HYST_MAX, `MHO_DIST_MAX,
		`MHO_DELAY_MAX};

	mho_top #(.MS_CYCLES(MS)) DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.meas_value(meas_value), .meas_valid(meas_valid), .meas_ok(meas_ok),
		.level_low(level_low), .edge_jump(edge_jump), .first_switch_output(first_q),
		.control_input(ctl), .second_switch_output(second_q), .analog_output(ana),
		.analog_enable(ana_en), .analog_is_voltage(ana_v), .laser_on(laser_on),
		.hold_value(hold_value), .hold_strobe(hold_strobe), .teach_code(teach_code),
		.teach_strobe(teach_strobe));
	mho_ctl_model CTL (.aclk(aclk), .control_input(ctl));

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task end_of_test;
		if (mismatches == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task guard(inout int n);
		n++;
		if (n > 20000) begin
			mismatches++;
			$display("MISMATCH %0t wait timed out", $time);
			end_of_test;
		end
	endtask
	task cmp_word(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task cmp_bit(input logic got, input logic exp, input string m);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t %s got %b", $time, m, got);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		bit pa, pw;
		n = 0;
		pa = 1;
		pw = 1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (pa || pw) begin
			@(negedge aclk);
			guard(n);
			@(posedge aclk);
			if (pa && awready) begin
				awvalid <= 1'b0;
				pa = 0;
			end
			if (pw && wready) begin
				wvalid <= 1'b0;
				pw = 0;
			end
		end
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			guard(n);
		end while (!bvalid);
		r = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			guard(n);
		end while (!arready);
		@(posedge aclk);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			guard(n);
		end while (!rvalid);
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask
	task automatic wait_evt(input bit t);
		int n;
		n = 0;
		do begin
			@(negedge aclk);
			guard(n);
		end while ((t ? teach_strobe : hold_strobe) !== 1'b1);
	endtask
	task automatic mp(input int x);
		@(posedge aclk);
		meas_value <= x;
		meas_valid <= 1'b1;
		@(posedge aclk);
		meas_valid <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask
	function automatic int exp_hold(int m, int v0, int d, int e, int vs);
		int k;
		k = (d > e) ? d : e;
		case (m)
			0: return vs;
			1: return v0 + k;
			2: return v0 - k;
			3: return 2 * k;
			default: return v0;
		endcase
	endfunction
	task automatic th(input int m, input bit pol);
		int v0, d, e, vs;
		v0 = $urandom_range(4000) - 2000;
		d = $urandom_range(3000, 1);
		e = $urandom_range(3000, 1);
		vs = $urandom_range(8000) - 4000;
		axw(`MHO_CTRL, 32'h0000_0001 | (pol << 2) | (m << 4), rs);
		@(posedge aclk);
		meas_value <= v0;
		CTL.level(!pol);
		repeat (8) @(posedge aclk);
		CTL.level(pol);
		repeat (8) @(posedge aclk);
		mp(v0 + d);
		mp(v0 - d);
		mp(v0 + e);
		mp(v0 - e);
		@(posedge aclk);
		meas_value <= (m == 0) ? vs : v0;
		CTL.level(!pol);
		wait_evt(0);
		cmp_word(hold_value, exp_hold(m, v0, d, e, vs), "hold value");
	endtask
	task automatic dstim(input int m, input bit c);
		@(posedge aclk);
		first_q <= !c;
		meas_ok <= !(m == 4 && c);
		level_low <= (m == 5 && c);
		edge_jump <= (m == 6 && c);
		mp(m == 2 ? (c ? 4100 : 4000) : (c ? 0 : 5000));
	endtask

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, meas_valid, level_low, edge_jump} = 8'h00;
		{awaddr, araddr, wdata, meas_value, first_q} = 0;
		meas_ok = 1'b1;
		mismatches = 0;
		checks_done = 0;
		aresetn = 1'b0;
		void'($urandom(32'h535fe75b));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			axr(i * 4, rd, rs);
			cmp_word(rd, rst[i], "reset value");
		end
		for (int i = 0; i < 5; i++) begin
			axw(4 + i * 4, cd[i], rs);
			axr(4 + i * 4, rd, rs);
			cmp_word(rd, ce[i], "range limit");
		end
		for (int i = 1; i < 8; i++)
			axw(i * 4, rst[i], rs);
		axr(8'h40, rd, rs);
		cmp_word(rs, 32'h0000_0002, "unmapped read");
		axw(8'h40, 32'h0000_0000, rs);
		cmp_word(rs, 32'h0000_0002, "unmapped write");
		axw(`MHO_CTRL, 32'h0000_0200, rs);
		axw(`MHO_CTRL, 32'h0000_4200, rs);
		axr(`MHO_CTRL, rd, rs);
		cmp_word(rd, 32'h0000_0200, "advanced mode gate");
		for (int m = 0; m < 7; m++) begin
			axw(`MHO_CTRL, 32'h0008_0200 | (m << 12), rs);
			for (int c = 1; c >= 0; c--) begin
				dstim(m, c);
				cmp_bit(second_q, c, "switch mode");
			end
		end
		axw(`MHO_CTRL, 32'h0000_8200, rs);
		dstim(0, 1);
		cmp_bit(second_q, 1'b0, "active low");
		axw(`MHO_DELAY, 32'h0000_0005, rs);
		for (int y = 1; y < 5; y++) begin
			axw(`MHO_CTRL, 32'h0000_0200 | (y << 16), rs);
			dstim(0, 0);
			repeat (60) @(posedge aclk);
			for (int c = 1; c >= 0; c--) begin
				dstim(0, c);
				cmp_bit(second_q, YE[(y - 1) * 4 + 2 * c + 1], "delay edge");
				repeat (60) @(posedge aclk);
				cmp_bit(second_q, YE[(y - 1) * 4 + 2 * c], "delay end");
			end
		end
		axw(`MHO_CTRL, 32'h0000_0000, rs);
		mp(-4000);
		cmp_word(ana, 32'h0000_0000, "analog low end");
		mp(4000);
		cmp_word(ana, 32'h0000_FFFF, "analog high end");
		v = $urandom_range(8000) - 4000;
		mp(v);
		ex = (v + 4000) * 65535 / 8000;
		cmp_bit(ana + 1 >= ex && ana <= ex + 1, 1'b1, "analog slope");
		cmp_bit(ana_en && !ana_v, 1'b1, "current output");
		axw(`MHO_CTRL, 32'h0000_0100, rs);
		mp(v);
		cmp_bit(ana_en && ana_v, 1'b1, "voltage output");
		axw(`MHO_CTRL, 32'h0000_0300, rs);
		mp(v);
		cmp_bit(ana_en || second_q || ana != 0, 1'b0, "output off");
		for (int m = 0; m < 5; m++)
			th(m, m[0]);
		for (int p = 0; p < 2; p++)
			for (int l = 0; l < 2; l++) begin
				axw(`MHO_CTRL, 32'h0000_0002 | (p << 2), rs);
				CTL.level(l);
				repeat (6) @(posedge aclk);
				cmp_bit(laser_on, !(l ^ p), "laser input");
			end
		axw(`MHO_CTRL, 32'h0000_0003, rs);
		fork
			CTL.pulse(1'b1, 20);
			begin
				repeat (8) @(posedge aclk);
				axr(`MHO_STATUS, rd, rs);
				cmp_word(rd[3:2], 32'h0000_0002, "line masked");
			end
		join
		repeat (6) @(posedge aclk);
		cmp_bit(laser_on, 1'b1, "input off laser");
		axr(`MHO_CTRL, rd, rs);
		cmp_word(rd, 32'h0000_0003, "input stays off");
		axw(`MHO_CTRL, 32'h0000_0000, rs);
		CTL.pulse(1'b1, 215 * MS);
		wait_evt(1);
		cmp_word(teach_code, 32'h0000_0002, "teach laser off code");
		repeat (4) @(posedge aclk);
		cmp_bit(laser_on, 1'b0, "teach laser off");
		CTL.pulse(1'b1, 290 * MS);
		wait_evt(1);
		cmp_word(teach_code, 32'h0000_0003, "teach laser on code");
		CTL.pulse(1'b1, 250 * MS);
		repeat (100) @(posedge aclk);
		cmp_word(teach_code, 32'h0000_0003, "teach out of tolerance");
		cmp_bit(laser_on, 1'b1, "teach laser on");
		axw(`MHO_CTRL, 32'h0000_000A, rs);
		repeat (400) @(posedge aclk);
		CTL.level(1'b1);
		repeat (200) @(posedge aclk);
		cmp_bit(laser_on, 1'b1, "debounce short");
		repeat (150) @(posedge aclk);
		cmp_bit(laser_on, 1'b0, "debounce long");
		end_of_test;
	end
endmodule // measurement_hold_output_control_tb

// ### verification/mho_ctl_model.sv
// external controller driving the control input line
`timescale 1ns/100ps
module mho_ctl_model (
	input  wire aclk,
	output reg  control_input
);
	initial control_input = 1'b0;
	task automatic pulse(input logic lvl, input int cycles);
		@(posedge aclk);
		control_input <= lvl;
		repeat (cycles) @(posedge aclk);
		control_input <= !lvl;
	endtask
	task automatic level(input logic lvl);
		@(posedge aclk);
		control_input <= lvl;
	endtask
endmodule // mho_ctl_model

// ### verification/mho_monitor.sv
// assertion checker for the hold and second output stage
`timescale 1ns/100ps
module mho_monitor #(
	parameter DW = 20
) (
	input wire               aclk,
	input wire               aresetn,
	input wire               s_axi_bvalid,
	input wire               s_axi_bready,
	input wire [1:0]         s_axi_bresp,
	input wire               s_axi_arvalid,
	input wire               s_axi_arready,
	input wire               s_axi_rvalid,
	input wire               s_axi_rready,
	input wire [31:0]        s_axi_rdata,
	input wire               second_switch_output,
	input wire [15:0]        analog_output,
	input wire               analog_enable,
	input wire               analog_is_voltage,
	input wire               laser_on,
	input wire signed [DW:0] hold_value,
	input wire               hold_strobe,
	input wire               teach_strobe
);
	default clocking mon_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	hold_pulse_a:
		assert property (hold_strobe |=> !hold_strobe) else $error("hold strobe too long");
	hold_stays_a:
		assert property ($changed(hold_value) |-> hold_strobe) else $error("hold moved");
	teach_pulse_a:
		assert property (teach_strobe |=> !teach_strobe) else $error("teach strobe too long");
	bresp_stand_a:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
			else $error("write response dropped");
	rdata_stand_a:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
			else $error("read data dropped");
	read_answer_a:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
	analog_excl_a:
		assert property (analog_enable |-> !second_switch_output) else $error("digital in analog");
	analog_off_a:
		assert property (!analog_enable [*2] |-> analog_output == 16'h0000) else $error("analog on");
	voltage_sub_a:
		assert property (analog_is_voltage |-> analog_enable) else $error("voltage not analog");

	hold_seen_c: cover property (hold_strobe);
	teach_seen_c: cover property (teach_strobe);
	laser_off_c: cover property (!laser_on);
	slverr_c: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule // mho_monitor

bind mho_top mho_monitor #(.DW(DW)) u_mon (.aclk(aclk), .aresetn(aresetn),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.second_switch_output(second_switch_output), .analog_output(analog_output),
	.analog_enable(analog_enable), .analog_is_voltage(analog_is_voltage), .laser_on(laser_on),
	.hold_value(hold_value), .hold_strobe(hold_strobe), .teach_strobe(teach_strobe));
